// *** hdl/clc_defs.vh ***
/*
 * clc_defs.vh: register offsets, field positions, reset values and sizes for the
 * configurable logic cell.
 * Assumes inclusion by the cell's design files only; definitions only.
 */
`ifndef CLC_DEFS_VH
`define CLC_DEFS_VH

// register byte offsets on the bus
`define CLC_OFF_POLARITY    12'h000
`define CLC_OFF_D1_SELECT   12'h004
`define CLC_OFF_G2_TERMS    12'h008
`define CLC_OFF_G1_TERMS    12'h00C
`define CLC_OFF_G3_TERMS    12'h010
`define CLC_OFF_G4_TERMS    12'h014
`define CLC_OFF_D234_SELECT 12'h018
`define CLC_OFF_CONTROL     12'h01C
`define CLC_OFF_SW_BITS     12'h020

// polarity register fields
`define CLC_POL_OUT_BIT     7
`define CLC_POL_MASK        8'h8F

// source select field
`define CLC_SEL_MASK        8'h1F

// control register: bit 7 enable, bit 5 output read-back, bits 2..0 function
`define CLC_CTL_EN_BIT      7
`define CLC_CTL_OUT_BIT     5
`define CLC_CTL_MASK        8'h87

// function codes
`define CLC_FN_AND_OR       3'h0
`define CLC_FN_OR_XOR       3'h1
`define CLC_FN_AND          3'h2
`define CLC_FN_SR           3'h3
`define CLC_FN_DFF_SR       3'h4
`define CLC_FN_DLAT_SR      3'h5
`define CLC_FN_JK_R         3'h6
`define CLC_FN_NAND         3'h7

// reset value of all cell registers
`define CLC_REG_RESET       8'h00

`endif

// *** hdl/clc_gate.v ***
/*
 * clc_gate.v: one data gate of the logic cell: OR of selected data terms, then
 * optional inversion.
 * Assumes data lines and select bits are on the same clock; purely combinational.
 */
`default_nettype none

module clc_gate (
    // data lines
    input  wire [3:0] dataLines,
    // term select: bit 2k+1 true data k, bit 2k inverted data k
    input  wire [7:0] termSelect,
    input  wire       invert,
    // gate result
    output wire       gateOut
);

    wire [7:0] terms;

    genvar k;
    generate
        for (k = 0; k < 4; k = k + 1) begin : g_term
            assign terms[2*k+1] = dataLines[k];
            assign terms[2*k]   = ~dataLines[k];
        end
    endgenerate

    // no term selected gives zero before inversion
    assign gateOut = (|(terms & termSelect)) ^ invert;

endmodule

`default_nettype wire

// *** hdl/clc_cell.v ***
/*
 * clc_cell.v: configurable logic cell with APB register access.
 * Assumes a single 250 MHz clock, synchronous active-high reset, pins that are
 * asynchronous to clk, and peripheral or clock sources already on clk.
 */
// Notes on behaviour
// - thirty-two candidate inputs are reduced through data selection to four logic lines.
// - four lines drive exactly one of eight functions with single output.
// - sources include pins, internal clocks, peripheral outputs and software bits.
// - cell output goes to peripherals and to an output pin.
// - polarity bit 7 set inverts the cell output.
// - polarity bits 3..0 invert gates four..one before the function.
// - data-one select bits 4..0 choose the source of data line one.
// - gate-two select bits pair true and inverted data, bit 7 true d4.
// - one function is clocked D flip-flop with set and reset from gates.
// - one function is transparent D latch with set and reset from gates.
// - one function is clocked J-K flip-flop with reset from gates.
// - unimplemented polarity bits 6..4 and select bits 7..5 read zero.
`include "clc_defs.vh"
`default_nettype none

module clc_cell #(
    parameter PIN_COUNT = 4,
    parameter CLK_COUNT = 4,
    parameter PER_COUNT = 16
) (
    // clock and reset
    input  wire        clk,
    input  wire        rst,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    // input sources
    input  wire [PIN_COUNT-1:0] pinIn,
    input  wire [CLK_COUNT-1:0] clockTaps,
    input  wire [PER_COUNT-1:0] periphIn,
    // cell result
    output reg         cellOutput,
    output wire        cellOutPin,
    output wire        cellOutPinOe
);

    localparam SW_COUNT = 32 - PIN_COUNT - CLK_COUNT - PER_COUNT;

    // registers
    reg [7:0] cellPolarityControl;
    reg [7:0] dataOneSourceSelect;
    reg [7:0] dataSourceSelect [1:3];
    reg [7:0] gateTwoTermSelect;
    reg [7:0] gateOneTermSelect;
    reg [7:0] gateThreeTermSelect;
    reg [7:0] gateFourTermSelect;
    reg [7:0] cellControl;
    reg [7:0] softwareBits;

    // pin synchronisers: three stages, change accepted when last two agree
    reg [PIN_COUNT-1:0] pinSync1;
    reg [PIN_COUNT-1:0] pinSync2;
    reg [PIN_COUNT-1:0] pinSync3;
    reg [PIN_COUNT-1:0] pinClean;

    always @(posedge clk) begin
        if (rst) begin
            pinSync1 <= {PIN_COUNT{1'b0}};
            pinSync2 <= {PIN_COUNT{1'b0}};
            pinSync3 <= {PIN_COUNT{1'b0}};
            pinClean <= {PIN_COUNT{1'b0}};
        end else begin
            pinSync1 <= pinIn;
            pinSync2 <= pinSync1;
            pinSync3 <= pinSync2;
            // a disagreement between the last two stages keeps the old level
            pinClean <= (pinSync2 & pinSync3) | (pinClean & (pinSync2 ^ pinSync3));
        end
    end

    // candidate source vector
    wire [31:0] sources;
    assign sources = {softwareBits[SW_COUNT-1:0], periphIn, clockTaps, pinClean};

    // data selectors reduce the sources to four lines
    wire [3:0] dataLines;
    assign dataLines[0] = sources[dataOneSourceSelect[4:0]];
    genvar d;
    generate
        for (d = 1; d < 4; d = d + 1) begin : g_dsel
            assign dataLines[d] = sources[dataSourceSelect[d][4:0]];
        end
    endgenerate

    // gates with per-gate polarity
    wire [3:0] gateLines;
    clc_gate u_gate1 (
        .dataLines  (dataLines),
        .termSelect (gateOneTermSelect),
        .invert     (cellPolarityControl[0]),
        .gateOut    (gateLines[0])
    );
    clc_gate u_gate2 (
        .dataLines  (dataLines),
        .termSelect (gateTwoTermSelect),
        .invert     (cellPolarityControl[1]),
        .gateOut    (gateLines[1])
    );
    clc_gate u_gate3 (
        .dataLines  (dataLines),
        .termSelect (gateThreeTermSelect),
        .invert     (cellPolarityControl[2]),
        .gateOut    (gateLines[2])
    );
    clc_gate u_gate4 (
        .dataLines  (dataLines),
        .termSelect (gateFourTermSelect),
        .invert     (cellPolarityControl[3]),
        .gateOut    (gateLines[3])
    );

    wire g1 = gateLines[0];
    wire g2 = gateLines[1];
    wire g3 = gateLines[2];
    wire g4 = gateLines[3];

    // storage element; clock edges of the gate lines are found by sampling,
    // so clocked functions act on the first clk edge that samples g1 high
    reg  stateBit;
    reg  g1Prev;
    reg  next_stateBit;
    wire g1Rise = g1 & ~g1Prev;
    wire [2:0] fnSel = cellControl[2:0];

    always @* begin
        next_stateBit = stateBit;
        case (fnSel)
            `CLC_FN_SR: begin
                // set wins when both are high
                if (g1 | g2)
                    next_stateBit = 1'b1;
                else if (g3 | g4)
                    next_stateBit = 1'b0;
            end
            `CLC_FN_DFF_SR: begin
                // set and reset override the clock
                if (g4)
                    next_stateBit = 1'b1;
                else if (g3)
                    next_stateBit = 1'b0;
                else if (g1Rise)
                    next_stateBit = g2;
            end
            `CLC_FN_DLAT_SR: begin
                // transparent while g3 high
                if (g4)
                    next_stateBit = 1'b1;
                else if (g1)
                    next_stateBit = 1'b0;
                else if (g3)
                    next_stateBit = g2;
            end
            `CLC_FN_JK_R: begin
                // j on g2, k on g4, reset on g3
                if (g3)
                    next_stateBit = 1'b0;
                else if (g1Rise) begin
                    case ({g2, g4})
                        2'b10:   next_stateBit = 1'b1;
                        2'b01:   next_stateBit = 1'b0;
                        2'b11:   next_stateBit = ~stateBit;
                        default: next_stateBit = stateBit;
                    endcase
                end
            end
            default: next_stateBit = stateBit;
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            stateBit <= 1'b0;
            g1Prev   <= 1'b0;
        end else begin
            stateBit <= next_stateBit;
            g1Prev   <= g1;
        end
    end

    // function select; latch modes show the updated state at once
    reg fnResult;
    always @* begin
        case (fnSel)
            `CLC_FN_AND_OR: fnResult = (g1 & g2) | (g3 & g4);
            `CLC_FN_OR_XOR: fnResult = (g1 | g2) ^ (g3 | g4);
            `CLC_FN_AND:    fnResult = g1 & g2 & g3 & g4;
            `CLC_FN_NAND:   fnResult = ~(g1 & g2 & g3 & g4);
            `CLC_FN_SR:     fnResult = next_stateBit;
            `CLC_FN_DLAT_SR: fnResult = next_stateBit;
            default:        fnResult = stateBit;
        endcase
    end

    // registered output; AOI and OR-XNOR come from the output invert
    always @(posedge clk) begin
        if (rst)
            cellOutput <= 1'b0;
        else if (cellControl[`CLC_CTL_EN_BIT])
            cellOutput <= fnResult ^ cellPolarityControl[`CLC_POL_OUT_BIT];
        else
            cellOutput <= 1'b0;
    end

    // pin copy of the result; driven only while the cell is enabled
    assign cellOutPin   = cellOutput;
    assign cellOutPinOe = cellControl[`CLC_CTL_EN_BIT];

    // apb: zero wait states, write on the access phase
    wire access   = psel & penable;
    wire wrAccess = access & pwrite & pstrb[0];
    reg  addrHit;
    reg  [7:0] readByte;

    always @* begin
        addrHit  = 1'b1;
        readByte = 8'h00;
        case (paddr)
            `CLC_OFF_POLARITY:    readByte = cellPolarityControl;
            `CLC_OFF_D1_SELECT:   readByte = dataOneSourceSelect;
            `CLC_OFF_G2_TERMS:    readByte = gateTwoTermSelect;
            `CLC_OFF_G1_TERMS:    readByte = gateOneTermSelect;
            `CLC_OFF_G3_TERMS:    readByte = gateThreeTermSelect;
            `CLC_OFF_G4_TERMS:    readByte = gateFourTermSelect;
            `CLC_OFF_CONTROL:
                readByte = (cellControl & `CLC_CTL_MASK) |
                           ({7'h00, cellOutput} << `CLC_CTL_OUT_BIT);
            `CLC_OFF_SW_BITS:     readByte = softwareBits;
            default:              addrHit  = 1'b0;
        endcase
    end

    // the three extra data selects pack into one word, one byte each
    wire d234Hit = (paddr == `CLC_OFF_D234_SELECT);

    assign pready  = 1'b1;
    assign pslverr = access & ~addrHit & ~d234Hit;

    always @(posedge clk) begin
        if (rst)
            prdata <= 32'h0000_0000;
        else if (psel & ~penable & ~pwrite)
            prdata <= d234Hit ? {8'h00, dataSourceSelect[3], dataSourceSelect[2],
                                 dataSourceSelect[1]} : {24'h00_0000, readByte};
    end

    always @(posedge clk) begin
        if (rst) begin
            cellPolarityControl <= `CLC_REG_RESET;
            dataOneSourceSelect <= `CLC_REG_RESET;
            dataSourceSelect[1] <= `CLC_REG_RESET;
            dataSourceSelect[2] <= `CLC_REG_RESET;
            dataSourceSelect[3] <= `CLC_REG_RESET;
            gateOneTermSelect   <= `CLC_REG_RESET;
            gateTwoTermSelect   <= `CLC_REG_RESET;
            gateThreeTermSelect <= `CLC_REG_RESET;
            gateFourTermSelect  <= `CLC_REG_RESET;
            cellControl         <= `CLC_REG_RESET;
            softwareBits        <= `CLC_REG_RESET;
        end else begin
            if (wrAccess) begin
                case (paddr)
                    `CLC_OFF_POLARITY:
                        cellPolarityControl <= pwdata[7:0] & `CLC_POL_MASK;
                    `CLC_OFF_D1_SELECT:
                        dataOneSourceSelect <= pwdata[7:0] & `CLC_SEL_MASK;
                    `CLC_OFF_G2_TERMS:   gateTwoTermSelect   <= pwdata[7:0];
                    `CLC_OFF_G1_TERMS:   gateOneTermSelect   <= pwdata[7:0];
                    `CLC_OFF_G3_TERMS:   gateThreeTermSelect <= pwdata[7:0];
                    `CLC_OFF_G4_TERMS:   gateFourTermSelect  <= pwdata[7:0];
                    `CLC_OFF_CONTROL:    cellControl <= pwdata[7:0] & `CLC_CTL_MASK;
                    `CLC_OFF_SW_BITS:    softwareBits <= pwdata[7:0];
                    default: ;
                endcase
            end
            if (access & pwrite & d234Hit) begin
                if (pstrb[0])
                    dataSourceSelect[1] <= pwdata[7:0] & `CLC_SEL_MASK;
                if (pstrb[1])
                    dataSourceSelect[2] <= pwdata[15:8] & `CLC_SEL_MASK;
                if (pstrb[2])
                    dataSourceSelect[3] <= pwdata[23:16] & `CLC_SEL_MASK;
            end
        end
    end

endmodule

`default_nettype wire

// *** verification/clc_cell_properties.sv ***
/* clc_cell_properties.sv: bus and output checks for the logic cell.
   Assumes the zero-wait bus timing and reset behaviour of clc_cell. */
`default_nettype none
module clc_cell_props (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // cell result
    input wire logic        cellOutput,
    input wire logic        cellOutPin,
    input wire logic        cellOutPinOe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic acc;
    logic ctlWr;
    assign acc = psel && penable;
    assign ctlWr = acc && pwrite && paddr == 12'h01C;
    a_ready_zero_wait: assert property (psel |-> pready) else $error("pready low");
    a_unmapped_refused: assert property (acc && paddr > 12'h020 |-> pslverr && prdata == 0)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (acc && paddr <= 12'h020 && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("bad pslverr");
    a_pin_follows: assert property (cellOutPin == cellOutput) else $error("pin differs");
    a_reset_quiet: assert property (disable iff (1'b0) rst |=> !cellOutput && !cellOutPinOe
        && prdata == 0) else $error("outputs not cleared by reset");
    a_pol_reserved: assert property (acc && !pwrite && paddr == 12'h000 |->
        prdata[6:4] == 3'h0 && prdata[31:8] == 0) else $error("polarity spare bits set");
    a_sel_reserved: assert property (acc && !pwrite && paddr == 12'h004 |->
        prdata[31:5] == 0) else $error("select spare bits set");
    a_gate2_byte: assert property (acc && !pwrite && paddr == 12'h008 |->
        prdata[31:8] == 0) else $error("gate two terms wider than a byte");
    a_oe_enable: assert property (ctlWr && pstrb[0] |=> cellOutPinOe == $past(pwdata[7]))
        else $error("pin enable does not follow write");
    a_oe_holds: assert property (!ctlWr |=> $stable(cellOutPinOe)) else $error("pin enable moved");
    a_rdata_holds: assert property (!psel |=> $stable(prdata)) else $error("prdata moved");
    c_refused: cover property (acc && pslverr);
    c_oe_on: cover property ($rose(cellOutPinOe));
    c_out_rise: cover property ($rose(cellOutput));
endmodule
bind clc_cell clc_cell_props u_props (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .cellOutput(cellOutput), .cellOutPin(cellOutPin),
    .cellOutPinOe(cellOutPinOe)
);
`default_nettype wire

// *** verification/clc_src_model.sv ***
/* clc_src_model.sv: source side of the logic cell: pins, clock taps, peripheral outputs.
   Assumes the bench sets levels after a clock edge; slow lags them by one cycle. */
`default_nettype none
module clc_src_model (
    // bench control
    input  wire logic        clk,
    input  wire logic        slow,
    input  wire logic [23:0] level,
    // sources into the cell
    output wire logic [3:0]  pinIn,
    output wire logic [3:0]  clockTaps,
    output wire logic [15:0] periphIn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] lag;
    always @(posedge clk) begin
        lag <= level;
    end
    // a slow source shows its change one cycle late
    assign {periphIn, clockTaps, pinIn} = slow ? lag : level;
endmodule
`default_nettype wire

// *** verification/tb.sv ***
/* tb.sv: self-checking bench for the logic cell over APB.
   Assumes the source model drives pins, taps and peripherals; pstrb stays all ones. */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, slow, q, g1p, e;
    logic        cellOutput, cellOutPin, cellOutPinOe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r, src;
    logic [3:0]  pstrb, pinIn, clockTaps;
    logic [15:0] periphIn;
    logic [23:0] level;
    logic [31:0] rbExp [3] = '{32'h0000_008F, 32'h0000_001F, 32'h0000_00FF};
    int          errCount = 0;
    int          nChecks = 0;
    clc_cell dut (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .pinIn(pinIn), .clockTaps(clockTaps), .periphIn(periphIn),
        .cellOutput(cellOutput), .cellOutPin(cellOutPin), .cellOutPinOe(cellOutPinOe)
    );
    clc_src_model srcs (
        .clk(clk), .slow(slow), .level(level),
        .pinIn(pinIn), .clockTaps(clockTaps), .periphIn(periphIn)
    );
    always #2 clk = ~clk;
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp) begin
            errCount++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one transfer; the extra idle edge keeps psel from being driven twice in one step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        int n;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic        y;
        apb(1, a, d, x, y);
    endtask
    task automatic step(input int f, input logic [3:0] g, input logic inv);
        case (f)
            0: q = (g[0] & g[1]) | (g[2] & g[3]);
            1: q = (g[0] | g[1]) ^ (g[2] | g[3]);
            2: q = &g;
            3: q = g[0] | g[1] | (!(g[2] | g[3]) & q);
            4: q = g[3] | (!g[2] & ((g[0] & !g1p) ? g[1] : q));
            5: q = g[3] | (!g[0] & (g[2] ? g[1] : q));
            6: q = !g[2] & ((g[0] & !g1p) ? (g[1] & !q) | (!g[3] & q) : q);
            default: q = !(&g);
        endcase
        g1p = g[0];
        wr(12'h000, {24'h00_0000, inv, 3'h0, g});
        repeat (6) @(posedge clk);
        chk("function", cellOutput, q ^ inv);
    endtask
    task summarize();
        $display("comparisons %0d mismatches %0d", nChecks, errCount);
        if (errCount == 0 && nChecks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clk);
        errCount++;
        summarize();
    end
    initial begin
        clk = 0;
        rst = 1;
        {psel, penable, pwrite, slow} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'hF;
        level = 24'h00_0000;
        repeat (16) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        for (int a = 0; a <= 36; a += 4) begin
            apb(0, 12'(a), 0, r, e);
            chk("reset value", r, 0);
            chk("response", e, a == 36);
        end
        for (int i = 0; i < 3; i++) begin
            wr(12'(4 * i), 32'hFFFF_FFFF);
            apb(0, 12'(4 * i), 0, r, e);
            chk("readback", r, rbExp[i]);
            wr(12'(4 * i), 32'h0000_0000);
        end
        for (int inv = 0; inv < 2; inv++) begin
            for (int f = 0; f < 8; f++) begin
                wr(12'h01C, 32'(128 + f));
                step(f, 4'h4, inv[0]);
                for (int g = 0; g < 16; g++) step(f, 4'(g), inv[0]);
            end
        end
        chk("pin enable", cellOutPinOe, 1);
        wr(12'h01C, 32'h0000_0082);
        wr(12'h000, 32'h0000_000E);
        wr(12'h00C, 32'h0000_0002);
        for (int c = 0; c < 32; c++) begin
            wr(12'h004, 32'(c));
            for (int v = 0; v < 2; v++) begin
                src = v ? ~(32'h0000_0001 << c) : 32'h0000_0001 << c;
                slow <= c[0];
                level <= src[23:0];
                wr(12'h020, {24'h00_0000, src[31:24]});
                repeat (8) @(posedge clk);
                chk("source", cellOutput, v == 0);
            end
        end
        wr(12'h000, 32'h0000_000D);
        wr(12'h00C, 32'h0000_0000);
        wr(12'h004, 32'h0000_0008);
        wr(12'h018, 32'h000B_0A09);
        wr(12'h020, 32'h0000_0000);
        for (int k = 0; k < 8; k++) begin
            wr(12'h008, 32'h0000_0001 << k);
            for (int v = 0; v < 2; v++) begin
                level <= 24'(v) << (8 + k / 2);
                repeat (8) @(posedge clk);
                chk("gate two", cellOutput, k[0] == v[0]);
            end
        end
        wr(12'h01C, 32'h0000_0000);
        repeat (4) @(posedge clk);
        chk("disabled output", cellOutput, 0);
        chk("pin enable off", cellOutPinOe, 0);
        summarize();
    end
endmodule
`default_nettype wire
